/* File: src/tsg_consts.svh */
`ifndef TSG_CONSTS_SVH
`define TSG_CONSTS_SVH

// ----------------------------------------
// Timing
// ----------------------------------------
`define TSG_CLK_HZ        10000000
`define TSG_ALARM_CLR_MS  30
`define TSG_ALARM_CLR_CYC ((`TSG_ALARM_CLR_MS * `TSG_CLK_HZ) / 1000)

// ----------------------------------------
// Terminals and codes
// ----------------------------------------
`define TSG_NUM_TERM      5
`define TSG_FN_W          5
`define TSG_FN_FAULT      5'h0c
`define TSG_FN_GUARD      5'h0d
`define TSG_CODE_NONE     5'h00
`define TSG_CODE_UV       5'h09
`define TSG_CODE_FAULT    5'h0c
`define TSG_CODE_GUARD    5'h0d

// ----------------------------------------
// Register map
// ----------------------------------------
`define TSG_ADR_W         4
`define TSG_ADR_FUNC      4'h0
`define TSG_ADR_STATUS    4'h4
`define TSG_ADR_IRQ_STAT  4'h8
`define TSG_ADR_IRQ_MASK  4'hc
`define TSG_FUNC_W        25
`define TSG_FUNC_RST      25'h00001ac
`define TSG_ST_STATE_LSB  0
`define TSG_ST_CODE_LSB   4
`define TSG_ST_HIST_LSB   10
`define TSG_ST_RUN_BIT    16
`define TSG_ST_GUARD_BIT  17
`define TSG_ST_NEED_BIT   18
`define TSG_IRQ_W         4
`define TSG_IRQ_FAULT     0
`define TSG_IRQ_GUARD     1
`define TSG_IRQ_UV        2
`define TSG_IRQ_CLEAR     3

`endif

/* File: src/tsg_pkg.sv */
package tsg_pkg;

   typedef enum logic [2:0] {
      ST_STOP       = 3'h0,
      ST_RUN        = 3'h1,
      ST_TRIP_FAULT = 3'h2,
      ST_TRIP_GUARD = 3'h3,
      ST_TRIP_UV    = 3'h4
   } tsg_state_t;

   typedef struct packed {
      logic       drive_en;
      logic       alarm;
      logic [4:0] code;
   } tsg_drive_t;

   typedef struct packed {
      logic uv;
      logic guard;
      logic fault;
   } tsg_hist_t;

endpackage

/* File: src/tsg_trip_guard.sv */
`include "tsg_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module tsg_trip_guard #(
   parameter int unsigned ALARM_CLR_CYC = `TSG_ALARM_CLR_CYC
) (
   input  wire logic                      clk_i,             // Control clock
   input  wire logic                      rst_i,             // Power-up reset
   input  wire logic [`TSG_NUM_TERM-1:0]  term_i,            // Intelligent inputs
   input  wire logic                      run_req_i,         // Run request level
   input  wire logic                      fault_clear_input_i, // Reset terminal
   input  wire logic                      keypad_reset_i,    // Keypad reset pulse
   input  wire logic                      undervolt_i,       // Undervoltage detect
   input  wire logic                      wb_cyc_i,          // Bus cycle
   input  wire logic                      wb_stb_i,          // Bus strobe
   input  wire logic                      wb_we_i,           // Bus write
   input  wire logic [`TSG_ADR_W-1:0]     wb_adr_i,          // Byte address
   input  wire logic [3:0]                wb_sel_i,          // Byte lanes
   input  wire logic [31:0]               wb_dat_i,          // Write data
   output logic [31:0]                    wb_dat_o,          // Read data
   output logic                           wb_ack_o,          // Bus ack
   output logic                           drive_en_o,        // Power output enable
   output logic                           alarm_o,           // Alarm output
   output logic [4:0]                     fault_code_o,      // Displayed code
   output logic                           irq_o              // Interrupt level
);

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic fn_any(input logic [`TSG_NUM_TERM-1:0] t,
                                   input logic [`TSG_FUNC_W-1:0]  f,
                                   input logic [`TSG_FN_W-1:0]    code);
      logic hit;
      hit = 1'b0;
      for (int i = 0; i < `TSG_NUM_TERM; i++) begin
         if (t[i] && f[i*`TSG_FN_W +: `TSG_FN_W] == code) hit = 1'b1;
      end
      return hit;
   endfunction

   function automatic logic [31:0] wmask(input logic [31:0] old,
                                         input logic [31:0] d,
                                         input logic [3:0]  sel);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) r[b*8 +: 8] = d[b*8 +: 8];
      end
      return r;
   endfunction

   function automatic logic is_trip(input tsg_pkg::tsg_state_t s);
      return s == tsg_pkg::ST_TRIP_FAULT || s == tsg_pkg::ST_TRIP_GUARD ||
             s == tsg_pkg::ST_TRIP_UV;
   endfunction

   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   tsg_pkg::tsg_state_t        state_r, state_nxt;
   tsg_pkg::tsg_drive_t        drv_r, drv_nxt;
   tsg_pkg::tsg_hist_t         hist_r, hist_nxt;
   logic                       need_r, need_nxt;
   logic                       pwr_up_r;
   logic                       fault_prev_r, run_prev_r, clr_prev_r, uv_prev_r;
   logic [`TSG_FUNC_W-1:0]     func_r, func_nxt;
   logic [`TSG_IRQ_W-1:0]      istat_r, istat_nxt, imask_r, imask_nxt;
   logic                       ack_nxt;
   logic [31:0]                dat_nxt, wr_full, func_w, mask_w;
   logic                       wr_en;
   logic                       fault_lvl, guard_en;
   logic                       fault_rise, run_rise, clr_fall, uv_rise;

   // ----------------------------------------
   // Input decode and edges
   // ----------------------------------------
   assign fault_lvl  = fn_any(term_i, func_r, `TSG_FN_FAULT);
   assign guard_en   = fn_any(term_i, func_r, `TSG_FN_GUARD);
   assign fault_rise = fault_lvl & ~fault_prev_r;
   assign run_rise   = run_req_i & ~run_prev_r;
   assign uv_rise    = undervolt_i & ~uv_prev_r;
   assign clr_fall   = (~fault_clear_input_i & clr_prev_r) | keypad_reset_i;

   // ----------------------------------------
   // Trip and start control
   // ----------------------------------------
   always_comb begin
      state_nxt = state_r;
      need_nxt  = need_r;
      case (state_r)
         tsg_pkg::ST_STOP: begin
            if (run_rise || clr_fall) need_nxt = 1'b0;
            if (fault_clear_input_i) begin
               state_nxt = tsg_pkg::ST_STOP;
            end else if (pwr_up_r) begin
               if (run_req_i) begin
                  state_nxt = guard_en ? tsg_pkg::ST_TRIP_GUARD
                                       : tsg_pkg::ST_RUN;
               end
            end else if (run_req_i && (!need_r || run_rise)) begin
               state_nxt = tsg_pkg::ST_RUN;
            end
         end
         tsg_pkg::ST_RUN: begin
            if (fault_clear_input_i || !run_req_i) begin
               state_nxt = tsg_pkg::ST_STOP;
            end
         end
         tsg_pkg::ST_TRIP_FAULT: begin
            if (clr_fall) begin
               state_nxt = (run_req_i && !guard_en) ? tsg_pkg::ST_RUN
                                                    : tsg_pkg::ST_STOP;
               need_nxt  = guard_en;
            end
         end
         tsg_pkg::ST_TRIP_GUARD: begin
            if (!run_req_i) begin
               state_nxt = tsg_pkg::ST_STOP;
            end else if (clr_fall) begin
               state_nxt = tsg_pkg::ST_RUN;
            end
         end
         tsg_pkg::ST_TRIP_UV: begin
            if (clr_fall) begin
               if (!run_req_i) begin
                  state_nxt = tsg_pkg::ST_STOP;
               end else if (guard_en) begin
                  state_nxt = tsg_pkg::ST_TRIP_GUARD;
               end else begin
                  state_nxt = tsg_pkg::ST_RUN;
               end
            end
         end
         default: begin
            state_nxt = tsg_pkg::ST_STOP;
         end
      endcase
      if (fault_rise) begin
         state_nxt = tsg_pkg::ST_TRIP_FAULT;
      end else if (uv_rise && state_r != tsg_pkg::ST_TRIP_FAULT) begin
         state_nxt = tsg_pkg::ST_TRIP_UV;
      end

      // Outputs follow the next state so trips act in one cycle
      drv_nxt.drive_en = state_nxt == tsg_pkg::ST_RUN;
      drv_nxt.alarm    = is_trip(state_nxt) && !fault_clear_input_i;
      case (state_nxt)
         tsg_pkg::ST_TRIP_FAULT: drv_nxt.code = `TSG_CODE_FAULT;
         tsg_pkg::ST_TRIP_GUARD: drv_nxt.code = `TSG_CODE_GUARD;
         tsg_pkg::ST_TRIP_UV:    drv_nxt.code = `TSG_CODE_UV;
         default:                drv_nxt.code = `TSG_CODE_NONE;
      endcase
      if (fault_clear_input_i) drv_nxt.code = `TSG_CODE_NONE;

      // History clears on reset; a new entry wins over the clear
      hist_nxt = fault_clear_input_i ? 3'h0 : hist_r;
      if (state_nxt != state_r) begin
         hist_nxt.fault = hist_nxt.fault | (state_nxt == tsg_pkg::ST_TRIP_FAULT);
         hist_nxt.guard = hist_nxt.guard | (state_nxt == tsg_pkg::ST_TRIP_GUARD);
         hist_nxt.uv    = hist_nxt.uv | (state_nxt == tsg_pkg::ST_TRIP_UV);
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_r      <= tsg_pkg::ST_STOP;
         need_r       <= 1'b0;
         drv_r        <= '0;
         hist_r       <= '0;
         pwr_up_r     <= 1'b1;
         fault_prev_r <= 1'b0;
         run_prev_r   <= 1'b0;
         clr_prev_r   <= 1'b0;
         uv_prev_r    <= 1'b0;
      end else begin
         state_r      <= state_nxt;
         need_r       <= need_nxt;
         drv_r        <= drv_nxt;
         hist_r       <= hist_nxt;
         pwr_up_r     <= 1'b0;
         fault_prev_r <= fault_lvl;
         run_prev_r   <= run_req_i;
         clr_prev_r   <= fault_clear_input_i;
         uv_prev_r    <= undervolt_i;
      end
   end

   assign drive_en_o   = drv_r.drive_en;
   assign alarm_o      = drv_r.alarm;
   assign fault_code_o = drv_r.code;

   // ----------------------------------------
   // Wishbone slave and registers
   // ----------------------------------------
   assign wr_en   = wb_ack_o & wb_cyc_i & wb_stb_i & wb_we_i;
   assign ack_nxt = wb_cyc_i & wb_stb_i & ~wb_ack_o;

   always_comb begin
      wr_full   = wmask(32'h0, wb_dat_i, wb_sel_i);
      func_w    = wmask({7'h0, func_r}, wb_dat_i, wb_sel_i);
      mask_w    = wmask({28'h0, imask_r}, wb_dat_i, wb_sel_i);
      func_nxt  = func_r;
      imask_nxt = imask_r;
      istat_nxt = istat_r;
      dat_nxt   = wb_dat_o;
      if (wr_en && wb_adr_i == `TSG_ADR_FUNC) func_nxt = func_w[`TSG_FUNC_W-1:0];
      if (wr_en && wb_adr_i == `TSG_ADR_IRQ_MASK) imask_nxt = mask_w[`TSG_IRQ_W-1:0];
      if (wr_en && wb_adr_i == `TSG_ADR_IRQ_STAT) istat_nxt = istat_r & ~wr_full[`TSG_IRQ_W-1:0];
      // New entries after the clear so set wins; history layout matches bits 2..0
      istat_nxt[`TSG_IRQ_UV:`TSG_IRQ_FAULT] = istat_nxt[`TSG_IRQ_UV:`TSG_IRQ_FAULT] |
                                              (hist_nxt & ~hist_r);
      if (is_trip(state_r) && !is_trip(state_nxt)) istat_nxt[`TSG_IRQ_CLEAR] = 1'b1;
      if (ack_nxt) begin
         dat_nxt = 32'h0;
         case (wb_adr_i)
            `TSG_ADR_FUNC:     dat_nxt[`TSG_FUNC_W-1:0] = func_r;
            `TSG_ADR_STATUS: begin
               dat_nxt[`TSG_ST_STATE_LSB +: 3] = state_r;
               dat_nxt[`TSG_ST_CODE_LSB +: 5]  = drv_r.code;
               dat_nxt[`TSG_ST_HIST_LSB +: 3]  = hist_r;
               dat_nxt[`TSG_ST_RUN_BIT]        = run_req_i;
               dat_nxt[`TSG_ST_GUARD_BIT]      = guard_en;
               dat_nxt[`TSG_ST_NEED_BIT]       = need_r;
            end
            `TSG_ADR_IRQ_STAT: dat_nxt[`TSG_IRQ_W-1:0] = istat_r;
            `TSG_ADR_IRQ_MASK: dat_nxt[`TSG_IRQ_W-1:0] = imask_r;
            default:           dat_nxt = 32'h0;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0;
         func_r   <= `TSG_FUNC_RST;
         istat_r  <= '0;
         imask_r  <= '0;
      end else begin
         wb_ack_o <= ack_nxt;
         wb_dat_o <= dat_nxt;
         func_r   <= func_nxt;
         istat_r  <= istat_nxt;
         imask_r  <= imask_nxt;
      end
   end

   assign irq_o = |(istat_r & imask_r);

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   logic [19:0] acnt_r, acnt_nxt;
   assign acnt_nxt = (fault_clear_input_i && alarm_o) ? acnt_r + 20'h1 : 20'h0;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         acnt_r <= 20'h0;
      end else begin
         acnt_r <= acnt_nxt;
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   sequence s_fault_clean;
      fault_rise && !fault_clear_input_i;
   endsequence
   sequence s_guard_cleared;
      state_r == tsg_pkg::ST_TRIP_GUARD && !run_req_i && !fault_rise && !uv_rise;
   endsequence
   sequence s_plain_rerun;
      run_rise && !fault_clear_input_i && !fault_rise && !uv_rise;
   endsequence

   chk_fault_code: assert property (s_fault_clean |=>
      state_r == tsg_pkg::ST_TRIP_FAULT && fault_code_o == `TSG_CODE_FAULT)
      else $error("fault rise did not latch code 12");
   chk_fault_coast: assert property (s_fault_clean |=>
      !drive_en_o && alarm_o)
      else $error("fault trip left output on or alarm off");
   chk_trip_hold: assert property (
      state_r == tsg_pkg::ST_TRIP_FAULT && !clr_fall |=> state_r == tsg_pkg::ST_TRIP_FAULT)
      else $error("fault trip left without reset");
   chk_guard_norun: assert property (
      state_r == tsg_pkg::ST_TRIP_FAULT && clr_fall && guard_en && !fault_rise && !uv_rise
      |=> state_r == tsg_pkg::ST_STOP && need_r)
      else $error("guarded fault clear did not stop");
   chk_fault_resume: assert property (
      state_r == tsg_pkg::ST_TRIP_FAULT && clr_fall && !guard_en && run_req_i &&
      !fault_rise && !uv_rise |=> drive_en_o)
      else $error("unguarded clear did not resume");
   chk_pwr_guard: assert property (
      pwr_up_r && run_req_i && !fault_clear_input_i && !fault_rise && !uv_rise
      |=> ($past(guard_en) ? fault_code_o == `TSG_CODE_GUARD : drive_en_o))
      else $error("power-up start decision wrong");
   chk_guard_rerun: assert property (
      s_guard_cleared ##1 s_plain_rerun |=> drive_en_o)
      else $error("run after guard clear did not start");
   chk_guard_pulse: assert property (
      state_r == tsg_pkg::ST_TRIP_GUARD && run_req_i && clr_fall && !fault_rise &&
      !uv_rise |=> state_r == tsg_pkg::ST_RUN ##0 drive_en_o)
      else $error("reset pulse did not restart from guard trip");
   chk_uv_guard: assert property (
      state_r == tsg_pkg::ST_TRIP_UV && clr_fall && run_req_i && guard_en &&
      !fault_rise && !uv_rise |=> fault_code_o == `TSG_CODE_GUARD)
      else $error("undervoltage clear skipped guard check");
   chk_alarm_clear: assert property (
      acnt_r < 20'(ALARM_CLR_CYC))
      else $error("alarm held during reset");
   chk_alarm_drop: assert property (fault_clear_input_i |=> !alarm_o)
      else $error("alarm still on after reset onset");

endmodule // tsg_trip_guard

`default_nettype wire

/* File: verification/tsg_far_side.sv */
`timescale 1ns/1ps
`default_nettype none

module tsg_far_side #(
   parameter int unsigned CLEAR_HOLD_CYC = 20, // Shortened reset-terminal hold
   parameter int unsigned START_WAIT_CYC = 30  // Shortened wait after power-up
) (
   input  wire logic  clk_i,          // Control clock
   output logic [4:0] term_o,         // Terminal levels
   output logic       run_req_o,      // Run request
   output logic       fault_clear_o,  // Reset terminal
   output logic       keypad_reset_o, // Keypad reset pulse
   output logic       undervolt_o     // Undervoltage detect
);
   logic [4:0] lvl_r;
   logic [4:0] noise_r;
   logic [4:0] noise_en_r;

   initial begin
      lvl_r = 5'h00;
      noise_r = 5'h00;
      noise_en_r = 5'h00;
      run_req_o = 1'b0;
      fault_clear_o = 1'b0;
      keypad_reset_o = 1'b0;
      undervolt_o = 1'b0;
   end

   // Unassigned contacts chatter freely
   assign term_o = (lvl_r & ~noise_en_r) | (noise_r & noise_en_r);

   always @(posedge clk_i) begin
      if (noise_en_r != 5'h00) begin
         noise_r <= 5'($urandom);
      end
   end

   // ----------------------------------------
   // Operator actions
   // ----------------------------------------
   task automatic set_term(input int idx, input logic v);
      @(posedge clk_i);
      lvl_r[idx] <= v;
   endtask

   task automatic set_noise(input logic [4:0] m);
      @(posedge clk_i);
      noise_en_r <= m;
   endtask

   task automatic set_run(input logic v);
      @(posedge clk_i);
      run_req_o <= v;
   endtask

   task automatic set_uv(input logic v);
      @(posedge clk_i);
      undervolt_o <= v;
   endtask

   task automatic keypad_pulse();
      @(posedge clk_i);
      keypad_reset_o <= 1'b1;
      @(posedge clk_i);
      keypad_reset_o <= 1'b0;
   endtask

   task automatic pulse_clear();
      @(posedge clk_i);
      fault_clear_o <= 1'b1;
      repeat (CLEAR_HOLD_CYC) @(posedge clk_i);
      fault_clear_o <= 1'b0;
   endtask

   task automatic start_run_after_wait();
      repeat (START_WAIT_CYC) @(posedge clk_i);
      run_req_o <= 1'b1;
   endtask
endmodule // tsg_far_side

`default_nettype wire

/* File: verification/trip_and_start_guard_tb.sv */
`include "tsg_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module trip_and_start_guard_tb;
   logic        clk_i;
   logic        rst_i;
   logic [4:0]  term;
   logic        run_req;
   logic        clr_in;
   logic        kp_rst;
   logic        uv;
   logic        wb_cyc;
   logic        wb_stb;
   logic        wb_we;
   logic [3:0]  wb_adr;
   logic [3:0]  wb_sel;
   logic [31:0] wb_wdat;
   logic [31:0] wb_rdat;
   logic        wb_ack;
   logic        drive_en;
   logic        alarm;
   logic [4:0]  code;
   logic        irq;
   logic [31:0] seen;
   logic [31:0] q;
   int          n_fail;
   int          n_compared;
   int          cyc_cnt;
   int          k;

   assign seen = {25'h0, drive_en, alarm, code};

   initial begin
      clk_i = 1'b0;
      forever #50 clk_i = ~clk_i;
   end

   initial begin
      rst_i = 1'b1;
      wb_cyc = 1'b0;
      wb_stb = 1'b0;
      wb_we = 1'b0;
      wb_adr = 4'h0;
      wb_sel = 4'h0;
      wb_wdat = 32'h0;
      n_fail = 0;
      n_compared = 0;
      cyc_cnt = 0;
   end

   always @(posedge clk_i) begin
      cyc_cnt <= cyc_cnt + 1;
      if (cyc_cnt == 20000) begin
         n_fail++;
         complete_run();
      end
   end

   tsg_trip_guard #(.ALARM_CLR_CYC(16)) i_tsg_trip_guard (
      .clk_i(clk_i), .rst_i(rst_i), .term_i(term), .run_req_i(run_req),
      .fault_clear_input_i(clr_in), .keypad_reset_i(kp_rst), .undervolt_i(uv),
      .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
      .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack),
      .drive_en_o(drive_en), .alarm_o(alarm), .fault_code_o(code), .irq_o(irq));

   tsg_far_side #(.CLEAR_HOLD_CYC(20), .START_WAIT_CYC(30)) i_tsg_far_side (
      .clk_i(clk_i), .term_o(term), .run_req_o(run_req), .fault_clear_o(clr_in),
      .keypad_reset_o(kp_rst), .undervolt_o(uv));

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic [31:0] outs(input logic d, input logic a, input logic [4:0] c);
      return {25'h0, d, a, c};
   endfunction

   task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic step(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask

   task automatic wb_xfer(input logic we, input logic [3:0] adr, input logic [3:0] sel,
                          input logic [31:0] d);
      @(posedge clk_i);
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we <= we;
      wb_adr <= adr;
      wb_sel <= sel;
      wb_wdat <= d;
      do begin
         @(posedge clk_i);
      end while (wb_ack !== 1'b1);
      q = wb_rdat;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      @(posedge clk_i);
   endtask

   task automatic power_up(input logic run, input logic guard);
      @(posedge clk_i);
      rst_i <= 1'b1;
      i_tsg_far_side.set_run(run);
      i_tsg_far_side.set_term(1, guard);
      i_tsg_far_side.set_term(0, 1'b0);
      i_tsg_far_side.set_uv(1'b0);
      step(2);
      check("reset outputs", seen, 32'h0);
      @(posedge clk_i);
      rst_i <= 1'b0;
      step(4);
   endtask

   task automatic complete_run();
      $display("compared %0d mismatches %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   // ----------------------------------------
   // Tests
   // ----------------------------------------
   initial begin
      void'($urandom(32'h19e7));
      i_tsg_far_side.set_noise(5'h1c);
      power_up(1'b1, 1'b0);
      check("power-up run", seen, outs(1'b1, 1'b0, 5'h00));
      wb_xfer(1'b0, `TSG_ADR_FUNC, 4'hf, 32'h0);
      check("func reset", q, 32'h1ac);
      wb_xfer(1'b1, 4'h2, 4'hf, 32'hffff_ffff);
      wb_xfer(1'b0, 4'h2, 4'hf, 32'h0);
      check("unmapped", q, 32'h0);
      wb_xfer(1'b1, `TSG_ADR_IRQ_MASK, {3'($urandom), 1'b0}, 32'hf);
      wb_xfer(1'b0, `TSG_ADR_IRQ_MASK, 4'hf, 32'h0);
      check("lane 0 off", q, 32'h0);
      $display("test reset done");

      i_tsg_far_side.set_term(0, 1'b1);
      step(3);
      check("fault trip", seen, outs(1'b0, 1'b1, `TSG_CODE_FAULT));
      check("irq masked", {31'h0, irq}, 32'h0);
      i_tsg_far_side.set_term(0, 1'b0);
      step(5);
      check("trip held", seen, outs(1'b0, 1'b1, `TSG_CODE_FAULT));
      wb_xfer(1'b0, `TSG_ADR_STATUS, 4'hf, 32'h0);
      check("state", {29'h0, q[2:0]}, 32'h2);
      check("history", {29'h0, q[12:10]}, 32'h1);
      wb_xfer(1'b1, `TSG_ADR_IRQ_MASK, 4'hf, 32'h1);
      step(2);
      check("irq set", {31'h0, irq}, 32'h1);
      wb_xfer(1'b1, `TSG_ADR_IRQ_STAT, 4'hf, 32'h1);
      step(2);
      check("irq w1c", {31'h0, irq}, 32'h0);
      fork
         i_tsg_far_side.pulse_clear();
         begin
            step(4);
            check("alarm clear", seen, outs(1'b0, 1'b0, 5'h00));
         end
      join
      step(3);
      check("resume", seen, outs(1'b1, 1'b0, 5'h00));
      wb_xfer(1'b0, `TSG_ADR_STATUS, 4'hf, 32'h0);
      check("history cleared", {29'h0, q[12:10]}, 32'h0);
      wb_xfer(1'b0, `TSG_ADR_IRQ_STAT, 4'hf, 32'h0);
      check("clear event", {31'h0, q[`TSG_IRQ_CLEAR]}, 32'h1);
      $display("test fault done");

      i_tsg_far_side.set_term(1, 1'b1);
      i_tsg_far_side.set_term(0, 1'b1);
      i_tsg_far_side.set_term(0, 1'b0);
      i_tsg_far_side.pulse_clear();
      step(3);
      check("no auto restart", {31'h0, drive_en}, 32'h0);
      i_tsg_far_side.set_run(1'b0);
      i_tsg_far_side.set_run(1'b1);
      step(3);
      check("run edge restart", {31'h0, drive_en}, 32'h1);
      $display("test guard fault done");

      power_up(1'b1, 1'b1);
      check("guard trip", seen, outs(1'b0, 1'b1, `TSG_CODE_GUARD));
      i_tsg_far_side.set_run(1'b0);
      step(3);
      check("run drop clears", seen, outs(1'b0, 1'b0, 5'h00));
      i_tsg_far_side.start_run_after_wait();
      step(3);
      check("run again", seen, outs(1'b1, 1'b0, 5'h00));
      power_up(1'b1, 1'b1);
      i_tsg_far_side.pulse_clear();
      step(3);
      check("pulse runs", seen, outs(1'b1, 1'b0, 5'h00));
      power_up(1'b1, 1'b1);
      i_tsg_far_side.keypad_pulse();
      step(3);
      check("keypad runs", seen, outs(1'b1, 1'b0, 5'h00));
      $display("test guard power-up done");

      power_up(1'b0, 1'b1);
      i_tsg_far_side.set_run(1'b1);
      i_tsg_far_side.set_uv(1'b1);
      step(3);
      check("uv trip", seen, outs(1'b0, 1'b1, `TSG_CODE_UV));
      i_tsg_far_side.set_uv(1'b0);
      i_tsg_far_side.pulse_clear();
      step(3);
      check("uv guard check", seen, outs(1'b0, 1'b1, `TSG_CODE_GUARD));
      $display("test undervoltage done");

      power_up(1'b1, 1'b0);
      k = 2 + int'($urandom % 3);
      i_tsg_far_side.set_noise(5'h1c & ~(5'h01 << k));
      i_tsg_far_side.set_term(k, 1'b0);
      wb_xfer(1'b1, `TSG_ADR_FUNC, 4'hf, 32'h1ac | (32'hc << (5 * k)));
      wb_xfer(1'b0, `TSG_ADR_FUNC, 4'hf, 32'h0);
      check("func write", q, 32'h1ac | (32'hc << (5 * k)));
      i_tsg_far_side.set_term(k, 1'b1);
      step(3);
      check("any terminal trip", seen, outs(1'b0, 1'b1, `TSG_CODE_FAULT));
      $display("test assignment done");
      complete_run();
   end
endmodule // trip_and_start_guard_tb

`default_nettype wire
